// >>> verilog/phase_adjust_map.vh
`ifndef PHASE_ADJUST_MAP_VH
`define PHASE_ADJUST_MAP_VH
// register byte addresses
`define ADDR_TRIGGER      8'h9D
`define ADDR_COARSE_BASE  8'h9E
`define ADDR_COARSE_LAST  8'hA5
`define ADDR_FINE_A       8'hA6
`define ADDR_FINE_B       8'hA7
`define ADDR_SYNC_CTRL    8'hA8
`define ADDR_SRC_SEL_A    8'hA9
`define ADDR_SRC_SEL_B    8'hAA
`define ADDR_FIXED        8'hAB
// field positions
`define SYNC_BIT          4
`define SEL_LO_MSB        2
`define SEL_HI_LSB        4
`define SEL_HI_MSB        6
// reset values
`define TRIGGER_RST       8'h00
`define COARSE_RST        5'h00
`define FINE_RST          4'h0
`define SEL4_RST          3'h0
`define SEL5_RST          3'h2
`define SEL6_RST          3'h0
`define SEL7_RST          3'h5
`define FIXED_VALUE       8'hF0
// source select codes
`define SRC_LOOP          3'h0
`define SRC_FRAC_A        3'h2
`define SRC_FRAC_B        3'h3
`define SRC_REF_ZERO      3'h4
`define SRC_REF_ONE       3'h5
`define SRC_CRYSTAL       3'h7
// fine phase step: sixteenths of a period
`define FINE_STEPS        5'h10
`endif

// >>> verilog/output_phase_adjust.v
// Summary of operation
// R1: rising trigger bit m starts coarse phase adjust on output m.
// R2: software waits for busy low before retriggering same output.
// R3: trigger must return low first; held-high bit never retriggers.
// R4: 5-bit coarse amount gives periods inserted, of selected source clock.
// R5: fractional outputs add fine offset in sixteenths of source period.
// R6: fine value takes effect only after sync bit toggles.
// R7: sync toggle clears all coarse delay settings.
// R8: sync bit rising holds loop-fed output dividers in reset.
// R9: sync bit falling releases dividers together, coarse adjustment zeroed.
// R10: 3-bit source select routes loop, fractional, references or crystal.
// R11: software never routes a reference above 250MHz directly.
// R12: select defaults loop, fractional a, loop, reference one.
// R13: software writes reserved bits zero; reads undefined.
// R14: trigger, coarse and fine fields reset to zero.
// R15: busy stays high from trigger until insertion completes.
`timescale 1ns/1ps
`include "phase_adjust_map.vh"

module output_phase_adjust #(
  parameter NUM_OUT = 8,
  parameter NUM_AUX = 4
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 resetn,
  // register port
  input  wire                 reg_wr,
  input  wire [7:0]           reg_addr,
  input  wire [7:0]           reg_wdata,
  output reg  [7:0]           reg_rdata,
  // source clock period ticks, one pulse per period of each output's source
  input  wire [NUM_OUT-1:0]   src_period_tick,
  // per-output busy and insert status, shared divider and fine phase controls towards the output stages
  output wire [NUM_OUT-1:0]   phase_adjust_busy,
  output wire [NUM_OUT-1:0]   period_insert,
  output reg                  divider_hold,
  output reg                  divider_release,
  output reg  [3:0]           fine_phase_active_a,
  output reg  [3:0]           fine_phase_active_b,
  // auxiliary output source selects
  output wire [3*NUM_AUX-1:0] aux_output_source_select,
  output wire [NUM_AUX-1:0]   aux_src_valid
);

  reg  [7:0]           coarse_phase_trigger_r;
  reg  [4:0]           coarse_phase_amount_r [0:NUM_OUT-1];
  reg  [3:0]           fine_phase_amount_a_r;
  reg  [3:0]           fine_phase_amount_b_r;
  reg                  output_divider_sync_r;
  reg  [2:0]           sel_r [0:NUM_AUX-1];
  reg  [4:0]           remain_r [0:NUM_OUT-1];
  reg  [NUM_OUT-1:0]   busy_r;
  reg  [NUM_OUT-1:0]   insert_r;
  wire                 wr_sync;
  wire                 sync_rise;
  wire                 sync_fall;
  wire [NUM_OUT-1:0]   trig_rise;
  wire                 wr_trigger;
  wire                 wr_fine_a;
  wire                 wr_fine_b;
  wire                 wr_sel_a;
  wire                 wr_sel_b;
  wire [NUM_OUT-1:0]   wr_coarse;
  wire                 sync_toggle;
  reg  [7:0]           coarse_rdata;
  integer              k;

  // register write decodes
  assign wr_trigger = reg_wr && (reg_addr == `ADDR_TRIGGER);
  assign wr_fine_a  = reg_wr && (reg_addr == `ADDR_FINE_A);
  assign wr_fine_b  = reg_wr && (reg_addr == `ADDR_FINE_B);
  assign wr_sel_a   = reg_wr && (reg_addr == `ADDR_SRC_SEL_A);
  assign wr_sel_b   = reg_wr && (reg_addr == `ADDR_SRC_SEL_B);

  // sync bit write edges
  assign wr_sync     = reg_wr && (reg_addr == `ADDR_SYNC_CTRL);
  assign sync_rise   = wr_sync && reg_wdata[`SYNC_BIT] && !output_divider_sync_r;
  assign sync_fall   = wr_sync && !reg_wdata[`SYNC_BIT] && output_divider_sync_r;
  assign sync_toggle = sync_rise || sync_fall;

  // trigger register, kept so a held-high bit can be told from a new rise
  always @(posedge clk)
  begin
    if (!resetn)
      coarse_phase_trigger_r <= `TRIGGER_RST; // R14
    else if (wr_trigger)
      coarse_phase_trigger_r <= reg_wdata;
  end

  // fine phase amounts as written, not yet in force
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      fine_phase_amount_a_r <= `FINE_RST; // R14
      fine_phase_amount_b_r <= `FINE_RST; // R14
    end
    else
    begin
      if (wr_fine_a)
        fine_phase_amount_a_r <= reg_wdata[3:0];
      if (wr_fine_b)
        fine_phase_amount_b_r <= reg_wdata[3:0];
    end
  end

  // sync bit, divider hold level and release pulse
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      output_divider_sync_r <= 1'b0;
      divider_hold          <= 1'b0;
      divider_release       <= 1'b0;
    end
    else
    begin
      divider_release <= sync_fall; // R9
      if (wr_sync)
        output_divider_sync_r <= reg_wdata[`SYNC_BIT];
      if (sync_rise)
        divider_hold <= 1'b1; // R8
      else if (sync_fall)
        divider_hold <= 1'b0; // R9
    end
  end

  // fine offsets in force, moved only across a sync toggle
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      fine_phase_active_a <= `FINE_RST;
      fine_phase_active_b <= `FINE_RST;
    end
    else if (sync_toggle)
    begin
      fine_phase_active_a <= fine_phase_amount_a_r; // R6 R5
      fine_phase_active_b <= fine_phase_amount_b_r; // R6 R5
    end
  end

  // per-output coarse adjust engines
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1)
    begin : gen_out
      // coarse amount write strobe for this output
      assign wr_coarse[g] = reg_wr && (reg_addr == `ADDR_COARSE_BASE + g);
      // trigger rises only on a 0 to 1 write, held-high bit is ignored
      assign trig_rise[g] = wr_trigger && reg_wdata[g] && !coarse_phase_trigger_r[g]; // R1 R3

      // coarse amount, wiped by any sync toggle
      always @(posedge clk)
      begin
        if (!resetn)
          coarse_phase_amount_r[g] <= `COARSE_RST; // R14
        else if (sync_toggle)
          coarse_phase_amount_r[g] <= `COARSE_RST; // R7
        else if (wr_coarse[g])
          coarse_phase_amount_r[g] <= reg_wdata[4:0];
      end

      // period insertion: a sync toggle aborts any adjust in flight
      always @(posedge clk)
      begin
        if (!resetn)
        begin
          remain_r[g] <= `COARSE_RST;
          busy_r[g]   <= 1'b0;
          insert_r[g] <= 1'b0;
        end
        else
        begin
          insert_r[g] <= 1'b0;
          if (sync_toggle)
          begin
            remain_r[g] <= `COARSE_RST; // R9
            busy_r[g]   <= 1'b0;
          end
          else if (trig_rise[g] && !busy_r[g])
          begin
            remain_r[g] <= coarse_phase_amount_r[g]; // R4
            busy_r[g]   <= (coarse_phase_amount_r[g] != `COARSE_RST); // R15
          end
          else if (busy_r[g] && src_period_tick[g])
          begin
            // one source period inserted per tick
            insert_r[g] <= 1'b1; // R4
            remain_r[g] <= remain_r[g] - 5'h01;
            if (remain_r[g] == 5'h01)
              busy_r[g] <= 1'b0; // R15
          end
        end
      end
    end
  endgenerate

  // status and insert pulses towards the output stages
  assign phase_adjust_busy = busy_r;
  assign period_insert     = insert_r;

  // source selects of the first auxiliary pair
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      sel_r[0] <= `SEL4_RST; // R12
      sel_r[1] <= `SEL5_RST; // R12
    end
    else if (wr_sel_a)
    begin
      sel_r[0] <= reg_wdata[`SEL_LO_MSB:0];
      sel_r[1] <= reg_wdata[`SEL_HI_MSB:`SEL_HI_LSB];
    end
  end

  // source selects of the second auxiliary pair
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      sel_r[2] <= `SEL6_RST; // R12
      sel_r[3] <= `SEL7_RST; // R12
    end
    else if (wr_sel_b)
    begin
      sel_r[2] <= reg_wdata[`SEL_LO_MSB:0];
      sel_r[3] <= reg_wdata[`SEL_HI_MSB:`SEL_HI_LSB];
    end
  end

  // routing codes, reserved codes flagged invalid
  generate
    for (g = 0; g < NUM_AUX; g = g + 1)
    begin : gen_aux
      reg code_ok;
      assign aux_output_source_select[3*g+2:3*g] = sel_r[g]; // R10

      // decode of the documented routing codes
      always @*
      begin
        case (sel_r[g])
          `SRC_LOOP, `SRC_FRAC_A, `SRC_FRAC_B:
            code_ok = 1'b1; // R10
          `SRC_REF_ZERO, `SRC_REF_ONE, `SRC_CRYSTAL:
            code_ok = 1'b1; // R10
          default:
            code_ok = 1'b0; // R10
        endcase
      end
      assign aux_src_valid[g] = code_ok;
    end
  endgenerate

  // coarse amount read word of the addressed output
  always @*
  begin
    coarse_rdata = 8'h00;
    for (k = 0; k < NUM_OUT; k = k + 1)
      if (reg_addr == `ADDR_COARSE_BASE + k)
        coarse_rdata = {3'h0, coarse_phase_amount_r[k]};
  end

  // read mux, reserved bits read zero
  always @*
  begin
    reg_rdata = 8'h00; // R13
    case (reg_addr)
      `ADDR_TRIGGER:
        reg_rdata = coarse_phase_trigger_r;
      `ADDR_FINE_A:
        reg_rdata = {4'h0, fine_phase_amount_a_r};
      `ADDR_FINE_B:
        reg_rdata = {4'h0, fine_phase_amount_b_r};
      `ADDR_SYNC_CTRL:
        reg_rdata = {3'h0, output_divider_sync_r, 4'h0};
      `ADDR_SRC_SEL_A:
        reg_rdata = {1'b0, sel_r[1], 1'b0, sel_r[0]};
      `ADDR_SRC_SEL_B:
        reg_rdata = {1'b0, sel_r[3], 1'b0, sel_r[2]};
      `ADDR_FIXED:
        reg_rdata = `FIXED_VALUE;
      default:
      begin
        // coarse block, anything else reads zero
        if (reg_addr >= `ADDR_COARSE_BASE && reg_addr <= `ADDR_COARSE_LAST)
          reg_rdata = coarse_rdata;
        else
          reg_rdata = 8'h00; // R13
      end
    endcase
  end

endmodule

// >>> testbench/phase_adjust_chk.sv
`timescale 1ns/1ps
module phase_adjust_chk #(
  parameter NUM_OUT = 8,
  parameter NUM_AUX = 4
) (
  input wire                 clk,
  input wire                 resetn,
  input wire                 reg_wr,
  input wire [7:0]           reg_addr,
  input wire [7:0]           reg_wdata,
  input wire [NUM_OUT-1:0]   phase_adjust_busy,
  input wire [NUM_OUT-1:0]   period_insert,
  input wire                 divider_hold,
  input wire                 divider_release,
  input wire [3:0]           fine_phase_active_a,
  input wire [3*NUM_AUX-1:0] aux_output_source_select,
  input wire [NUM_AUX-1:0]   aux_src_valid
);
  // sync control write strobe
  wire sw = reg_wr && reg_addr == 8'hA8;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_hold; sw && reg_wdata[4] && !divider_hold |=> divider_hold; endproperty
  a_hold: assert property (p_hold) else $error("hold not set");
  property p_abort; $rose(divider_hold) |-> phase_adjust_busy == 0; endproperty
  a_abort: assert property (p_abort) else $error("busy survives sync");
  property p_rel; sw && !reg_wdata[4] && divider_hold |=> !divider_hold && divider_release; endproperty
  a_rel: assert property (p_rel) else $error("release missing");
  property p_pulse; divider_release |=> !divider_release; endproperty
  a_pulse: assert property (p_pulse) else $error("release too long");
  property p_ins; period_insert[0] |-> $past(phase_adjust_busy[0]); endproperty
  a_ins: assert property (p_ins) else $error("insert while idle");
  property p_start; $rose(phase_adjust_busy[0]) |-> $past(reg_wr && reg_addr == 8'h9D && reg_wdata[0]); endproperty
  a_start: assert property (p_start) else $error("busy without trigger");
  property p_fine; $changed(fine_phase_active_a) |-> $changed(divider_hold); endproperty
  a_fine: assert property (p_fine) else $error("fine moved without sync");
  property p_val; aux_src_valid[0] == (aux_output_source_select[2:0] != 3'h1 && aux_output_source_select[2:0] != 3'h6);
  endproperty
  a_val: assert property (p_val) else $error("valid flag wrong");
endmodule
bind output_phase_adjust phase_adjust_chk #(.NUM_OUT(NUM_OUT), .NUM_AUX(NUM_AUX)) chk_u (.*);

// >>> testbench/tb_output_phase_adjust.sv
`timescale 1ns/1ps
`include "phase_adjust_map.vh"
module tb_output_phase_adjust;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         reg_wr = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg  [7:0]  src_period_tick = 8'h00;
  wire [7:0]  reg_rdata;
  wire [7:0]  phase_adjust_busy;
  wire [7:0]  period_insert;
  wire        divider_hold;
  wire        divider_release;
  wire [3:0]  fine_phase_active_a;
  wire [3:0]  fine_phase_active_b;
  wire [11:0] aux_output_source_select;
  wire [3:0]  aux_src_valid;
  integer     n_fail = 0;
  integer     tests_run = 0;
  integer     cyc = 0;
  integer     i;
  integer     n;
  // block under test
  output_phase_adjust dut_u (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .src_period_tick(src_period_tick),
    .phase_adjust_busy(phase_adjust_busy), .period_insert(period_insert), .divider_hold(divider_hold),
    .divider_release(divider_release), .fine_phase_active_a(fine_phase_active_a),
    .fine_phase_active_b(fine_phase_active_b), .aux_output_source_select(aux_output_source_select),
    .aux_src_valid(aux_src_valid));
  always #5 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  task close_out;
  begin
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task chk(input string nm, input [11:0] e, input [11:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(posedge clk);
    reg_addr <= a;
    #1;
    chk("rdata", e, reg_rdata);
  end
  endtask
  task tk;
  begin
    @(posedge clk);
    src_period_tick <= 8'h01;
    @(posedge clk);
    src_period_tick <= 8'h00;
    #1;
    n = n + period_insert[0];
  end
  endtask
  task t_reset;
  begin
    rd(`ADDR_TRIGGER, 8'h00);
    rd(`ADDR_COARSE_BASE, 8'h00);
    rd(`ADDR_FINE_A, 8'h00);
    rd(`ADDR_SRC_SEL_A, 8'h20);
    rd(`ADDR_SRC_SEL_B, 8'h50);
    chk("aux_sel", 12'hA10, aux_output_source_select);
    $display("t_reset done");
  end
  endtask
  task t_coarse;
  begin
    n = 0;
    wr(`ADDR_COARSE_BASE, 8'h1F);
    wr(`ADDR_TRIGGER, 8'h01);
    chk("busy", 1'b1, phase_adjust_busy[0]);
    for (i = 0; i < 32; i = i + 1)
      tk;
    chk("inserts", 12'd31, n[11:0]);
    chk("busy", 1'b0, phase_adjust_busy[0]);
    wr(`ADDR_TRIGGER, 8'h01);
    chk("busy", 1'b0, phase_adjust_busy[0]);
    wr(`ADDR_TRIGGER, 8'h00);
    wr(`ADDR_COARSE_BASE, 8'h00);
    wr(`ADDR_TRIGGER, 8'h01);
    chk("busy", 1'b0, phase_adjust_busy[0]);
    wr(`ADDR_TRIGGER, 8'h00);
    $display("t_coarse done");
  end
  endtask
  task t_sync;
  begin
    wr(`ADDR_FINE_A, 8'h05);
    wr(`ADDR_FINE_B, 8'h03);
    chk("fine", 4'h0, fine_phase_active_a);
    chk("fine_b", 4'h0, fine_phase_active_b);
    wr(`ADDR_COARSE_BASE + 8'h01, 8'h02);
    wr(`ADDR_TRIGGER, 8'h02);
    wr(`ADDR_SYNC_CTRL, 8'h10);
    chk("hold", 1'b1, divider_hold);
    chk("busy", 8'h00, phase_adjust_busy);
    chk("fine", 4'h5, fine_phase_active_a);
    chk("fine_b", 4'h3, fine_phase_active_b);
    rd(`ADDR_COARSE_BASE + 8'h01, 8'h00);
    wr(`ADDR_SYNC_CTRL, 8'h00);
    chk("release", 1'b1, divider_release);
    chk("hold", 1'b0, divider_hold);
    @(posedge clk);
    #1;
    chk("release", 1'b0, divider_release);
    wr(`ADDR_TRIGGER, 8'h00);
    $display("t_sync done");
  end
  endtask
  task t_sel;
  begin
    // reference codes used here stand for slow references only
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(`ADDR_SRC_SEL_A, i[7:0]);
      chk("sel", i[11:0], aux_output_source_select[2:0]);
      chk("valid", (i != 1 && i != 6), aux_src_valid[0]);
    end
    rd(`ADDR_FIXED, `FIXED_VALUE);
    $display("t_sel done");
  end
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_coarse;
    t_sync;
    t_sel;
    close_out;
  end
endmodule
